// ==== sse_chk_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module sse_chk
  import sse_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic clk_en_in,
  input wire logic reset_n_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic scl_oe_out,
  input wire logic sda_oe_out,
  // Software side
  input wire sse_cfg_s cfg_in,
  input wire sse_sw_s sw_in,
  input wire sse_stat_s stat_out,
  input wire logic [7:0] shift_buffer_out,
  input wire logic [7:0] own_address_out
);
  // ----------------------------------------
  // Bus and software relations
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  hold_low_a:
    assert property (!stat_out.clock_release_bit && !scl_in |-> ##[0:5] scl_oe_out)
    else $error("clock not held");
  release_a:
    assert property (sw_in.clock_release_set && !stat_out.address_update_flag
      |-> ##[1:4] !scl_oe_out)
    else $error("clock not released");
  own_addr_a:
    assert property (sw_in.addr_write && clk_en_in |=> own_address_out == $past(sw_in.wdata)
      && !stat_out.address_update_flag)
    else $error("own address write lost");
  buf_write_a:
    assert property (sw_in.buf_write && clk_en_in |=> stat_out.buffer_full_flag
      && shift_buffer_out == $past(sw_in.wdata))
    else $error("buffer load lost");
  nack_quiet_a:
    assert property (stat_out.ack_window_flag && cfg_in.ack_value_select
      && !stat_out.read_status |=> !sda_oe_out)
    else $error("data line pulled on not-acknowledge");
  ackwin_low_a:
    assert property ($rose(stat_out.ack_window_flag) |-> !scl_in)
    else $error("ack window raised with clock high");
  rack_high_a:
    assert property ($changed(stat_out.received_ack_flag) |-> scl_in)
    else $error("received ack moved with clock low");
  sda_on_low_a:
    assert property ($changed(sda_oe_out) |-> !$past(scl_in))
    else $error("data line moved while clock high");
endmodule
bind sse_slave_engine sse_chk u_chk (
  .clk_sys_in, .clk_en_in, .reset_n_in, .scl_in, .scl_oe_out, .sda_oe_out, .cfg_in, .sw_in,
  .stat_out, .shift_buffer_out, .own_address_out
);
`default_nettype wire

// ==== sse_defs.svh ====
`ifndef SSE_DEFS_SVH
`define SSE_DEFS_SVH
// ----------------------------------------
// Bit counting and addressing constants
// ----------------------------------------
`define SSE_LAST_DATA_BIT 4'h7
`define SSE_ACK_SLOT 4'h8
`define SSE_BIT_ZERO 4'h0
`define SSE_BIT_STEP 4'h1
`define SSE_TEN_HI_PREFIX 5'h1e
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSE_OWN_ADDR_RST 8'h00
`define SSE_BYTE_RST 8'h00
`define SSE_CKP_RST 1'b1
`endif

// ==== sse_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module sse_master #(
  parameter int HALF = 40
) (
  // Link clock and resolved wires
  input wire logic clk_link_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic jam_in,
  // Pull-low enables
  output var logic scl_oe_out,
  output var logic sda_oe_out
);
  // ----------------------------------------
  // Master bit engine
  // ----------------------------------------
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_link_in);
  endtask
  // Honours stretching, bounded so a stuck clock cannot hang us
  task automatic rise();
    scl_oe_out = 1'b0;
    for (int n = 0; n < 40000 && scl_in !== 1'b1; n++) begin
      tick(1);
    end
  endtask
  // Data moves well after the fall, never near a clock edge
  task automatic clk_bit(input logic b, output logic r);
    tick(8);
    sda_oe_out = !b || jam_in;
    tick(HALF);
    rise();
    tick(HALF / 2);
    r = sda_in;
    tick(HALF / 2);
    scl_oe_out = 1'b1;
  endtask
  task automatic start();
    sda_oe_out = 1'b1;
    tick(HALF);
    scl_oe_out = 1'b1;
  endtask
  task automatic stop();
    tick(8);
    sda_oe_out = 1'b1;
    tick(HALF);
    rise();
    tick(HALF);
    sda_oe_out = 1'b0;
    tick(HALF);
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
      q[i] = r;
    end
    clk_bit(last, r);
    ack = !r;
  endtask
endmodule
`default_nettype wire

// ==== sse_pkg.sv ====
package sse_pkg;
  typedef enum logic [3:0] {
    SSE_IDLE    = 4'b0001,
    SSE_RX_ADDR = 4'b0010,
    SSE_RX_DATA = 4'b0100,
    SSE_TX_DATA = 4'b1000
  } sse_phase_e;

  typedef struct packed {
    logic address_hold_enable;
    logic data_hold_enable;
    logic stretch_enable;
    logic ack_value_select;
    logic ten_bit_mode;
    logic slave_collision_detect_enable;
  } sse_cfg_s;

  typedef struct packed {
    logic clock_release_set;
    logic buf_read;
    logic buf_write;
    logic addr_write;
    logic event_clear;
    logic collision_clear;
    logic overflow_clear;
    logic [7:0] wdata;
  } sse_sw_s;

  typedef struct packed {
    logic port_event_flag;
    logic clock_release_bit;
    logic ack_window_flag;
    logic buffer_full_flag;
    logic receive_overflow_flag;
    logic received_ack_flag;
    logic collision_event_flag;
    logic address_update_flag;
    logic read_status;
    logic data_not_addr;
    logic start_seen;
    logic stop_seen;
  } sse_stat_s;

  typedef struct packed {
    logic bit_val;
    logic tog;
  } sse_link_s;

  typedef struct packed {
    sse_phase_e phase;
    logic [3:0] bitcnt;
    logic [7:0] rx_sr;
    logic [7:0] shift_register;
    logic [7:0] shift_buffer;
    logic [7:0] own_address;
    sse_stat_s stat;
    logic low_stage;
    logic prior_match;
    logic nack_force;
    logic ack_hold;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic scl_oe;
    logic sda_oe;
  } sse_core_s;
endpackage

// ==== sse_slave_engine.sv ====
// Functional notes
// RULE1: Address hold: event, release bit cleared after bit eight.
// RULE2: Data hold: event, release bit cleared after bit eight.
// RULE3: Ack-window flag marks events before acknowledge slot.
// RULE4: Software picks ack level, device drives it.
// RULE5: Event after ninth fall unless not-acknowledge sent.
// RULE6: Stretch enable holds clock after acknowledge slot.
// RULE7: Not-acknowledge or Stop ends reception; stop flag.
// RULE8: Read address: read status, buffer load, acknowledge.
// RULE9: After read address acknowledge, hold clock low.
// RULE10: Buffer write loads shifter; bits change on falls.
// RULE11: Master acknowledge latched on ninth rising edge.
// RULE12: Master not-acknowledge: no hold, event, go idle.
// RULE13: Event on ninth fall of each sent byte.
// RULE14: Collision while sending: flag, go idle.
// RULE15: Read address with hold: two holds and events.
// RULE16: Buffer read clears full flag; load sets it.
// RULE17: Software loads transmit data only after acknowledge.
// RULE18: Master ends reads with not-acknowledge.
// RULE19: Ten-bit high write match sets update flag, holds.
// RULE20: Low byte always flags; mismatch leaves buffer alone. Code sets the update flag only when the low byte is acknowledged.
// RULE21: Own address written only after acknowledge.
// RULE22: Ten-bit data bytes flag, stretch when enabled.
// RULE23: High byte compared to 11110, A9, A8, 0.
// RULE24: Own-address write clears update flag, releases clock.
// RULE25: No acknowledge when buffer full or overflow set.
// RULE26: Bus lines pass two flops before detection.
`timescale 1ns/10ps
`default_nettype none
`include "sse_defs.svh"
module sse_slave_engine
  import sse_pkg::*;
(
  // System clock, enable and reset
  input wire logic clk_sys_in,
  input wire logic clk_en_in,
  input wire logic reset_n_in,
  // Link clock, tied to the SCL wire
  input wire logic scl_link_in,
  // Bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Software side
  input wire sse_cfg_s cfg_in,
  input wire sse_sw_s sw_in,
  output sse_stat_s stat_out,
  output logic [7:0] shift_buffer_out,
  output logic [7:0] own_address_out
);
  // ----------------------------------------
  // Link domain: data bit on each SCL rise
  // ----------------------------------------
  // Bit is held until the next rise, long after the toggle has crossed
  sse_link_s lk_q;
  sse_link_s lk_d;

  always_comb begin
    lk_d.bit_val = sda_in;
    lk_d.tog = ~lk_q.tog;
  end

  always_ff @(posedge scl_link_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // ----------------------------------------
  // System domain state
  // ----------------------------------------
  sse_core_s q;
  sse_core_s d;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic bit_ev;
  logic ack_level;
  logic addr_match;
  logic low_hit;
  logic overflow;
  logic ten_low;
  logic any_hold;
  logic hold_req;

  function automatic logic hi_byte_hit(input logic [7:0] rx, input logic [7:0] own);
    hi_byte_hit = (rx[7:1] == {`SSE_TEN_HI_PREFIX, own[2:1]});
  endfunction

  always_comb begin
    d = q;
    // Two flops before any detection; s3 only feeds edge compare
    d.scl_s1 = scl_in; // see RULE26
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.tog_s1 = lk_q.tog;
    d.tog_s2 = q.tog_s1;
    d.tog_s3 = q.tog_s2;
    scl_fall = q.scl_s3 & ~q.scl_s2;
    start_det = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    stop_det = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
    bit_ev = q.tog_s2 ^ q.tog_s3;
    ack_level = q.nack_force | (q.ack_hold & cfg_in.ack_value_select); // see RULE4
    ten_low = cfg_in.ten_bit_mode & q.low_stage;
    low_hit = (q.rx_sr == q.own_address);
    overflow = q.stat.buffer_full_flag | q.stat.receive_overflow_flag;
    any_hold = cfg_in.address_hold_enable | cfg_in.data_hold_enable;
    if (!cfg_in.ten_bit_mode) begin
      addr_match = (q.rx_sr[7:1] == q.own_address[7:1]);
    end else if (!q.low_stage) begin
      // Read form of the high byte only after a full write match
      addr_match = hi_byte_hit(q.rx_sr, q.own_address) & (~q.rx_sr[0] | q.prior_match); // see RULE23
    end else begin
      addr_match = 1'b1;
    end

    // Software actions first so hardware sets win
    if (sw_in.event_clear) begin
      d.stat.port_event_flag = 1'b0;
    end
    if (sw_in.collision_clear) begin
      d.stat.collision_event_flag = 1'b0;
    end
    if (sw_in.overflow_clear) begin
      d.stat.receive_overflow_flag = 1'b0;
    end
    if (sw_in.buf_read) begin
      d.stat.buffer_full_flag = 1'b0; // see RULE16
    end
    if (sw_in.clock_release_set) begin
      d.stat.clock_release_bit = 1'b1;
    end
    if (sw_in.addr_write) begin
      d.own_address = sw_in.wdata;
      d.stat.address_update_flag = 1'b0; // see RULE24
    end
    if (sw_in.buf_write) begin
      d.shift_buffer = sw_in.wdata;
      d.shift_register = sw_in.wdata; // see RULE10
      d.stat.buffer_full_flag = 1'b1; // see RULE16
    end

    if (start_det) begin
      // Start and Restart both rearm address reception
      d.phase = SSE_RX_ADDR;
      // The Start's own SCL fall wraps this to zero, so it never counts as a bit
      d.bitcnt = `SSE_BIT_ZERO - `SSE_BIT_STEP;
      d.low_stage = 1'b0;
      d.nack_force = 1'b0;
      d.stat.ack_window_flag = 1'b0;
      d.stat.start_seen = 1'b1;
      d.stat.stop_seen = 1'b0;
    end else if (stop_det) begin
      d.phase = SSE_IDLE;
      d.prior_match = 1'b0;
      d.stat.ack_window_flag = 1'b0;
      d.stat.stop_seen = 1'b1; // see RULE7
      d.stat.start_seen = 1'b0;
    end else begin
      if (bit_ev) begin
        unique case (q.phase)
          SSE_RX_ADDR, SSE_RX_DATA: begin
            if (q.bitcnt <= `SSE_LAST_DATA_BIT) begin
              d.rx_sr = {q.rx_sr[6:0], lk_q.bit_val};
            end
          end
          SSE_TX_DATA: begin
            if (q.bitcnt == `SSE_ACK_SLOT) begin
              d.stat.received_ack_flag = lk_q.bit_val; // see RULE11
            end else if (cfg_in.slave_collision_detect_enable && !q.sda_oe &&
                         !lk_q.bit_val) begin
              d.stat.collision_event_flag = 1'b1; // see RULE14
              d.phase = SSE_IDLE;
            end
          end
          SSE_IDLE: begin
          end
        endcase
      end
      if (scl_fall && q.phase != SSE_IDLE) begin
        d.bitcnt = q.bitcnt + `SSE_BIT_STEP;
        if (q.bitcnt == `SSE_LAST_DATA_BIT) begin
          unique case (q.phase)
            SSE_RX_ADDR: begin
              if (!addr_match) begin
                // Silent drop; a failed high byte also forgets the old match
                d.phase = SSE_IDLE;
                if (cfg_in.ten_bit_mode) begin
                  d.prior_match = 1'b0;
                end
              end else begin
                d.nack_force = overflow; // see RULE25
                if (overflow) begin
                  d.stat.receive_overflow_flag = 1'b1;
                end else if (!(ten_low && !low_hit)) begin
                  d.shift_buffer = q.rx_sr; // see RULE8
                  d.stat.buffer_full_flag = 1'b1; // see RULE20
                end
                if (!ten_low) begin
                  d.stat.read_status = q.rx_sr[0]; // see RULE8
                end
                d.stat.data_not_addr = 1'b0;
                d.ack_hold = cfg_in.address_hold_enable;
                d.stat.ack_window_flag = any_hold; // see RULE3
                if (cfg_in.address_hold_enable) begin
                  d.stat.port_event_flag = 1'b1; // see RULE1
                  d.stat.clock_release_bit = 1'b0; // see RULE15
                end
              end
            end
            SSE_RX_DATA: begin
              d.nack_force = overflow; // see RULE25
              if (overflow) begin
                d.stat.receive_overflow_flag = 1'b1;
              end else begin
                d.shift_buffer = q.rx_sr;
                d.stat.buffer_full_flag = 1'b1;
              end
              d.stat.data_not_addr = 1'b1;
              d.ack_hold = cfg_in.data_hold_enable;
              d.stat.ack_window_flag = any_hold; // see RULE3
              if (cfg_in.data_hold_enable) begin
                d.stat.port_event_flag = 1'b1; // see RULE2
                d.stat.clock_release_bit = 1'b0;
              end
            end
            SSE_TX_DATA: begin
              d.shift_register = {q.shift_register[6:0], 1'b0};
            end
            SSE_IDLE: begin
            end
          endcase
        end else if (q.bitcnt == `SSE_ACK_SLOT) begin
          d.bitcnt = `SSE_BIT_ZERO;
          d.stat.ack_window_flag = 1'b0;
          unique case (q.phase)
            SSE_TX_DATA: begin
              d.stat.port_event_flag = 1'b1; // see RULE13
              if (q.stat.received_ack_flag) begin
                d.phase = SSE_IDLE; // see RULE12
              end else begin
                d.stat.clock_release_bit = 1'b0;
              end
            end
            SSE_RX_ADDR, SSE_RX_DATA: begin
              if (ack_level) begin
                d.phase = SSE_IDLE; // see RULE7
              end else begin
                d.stat.port_event_flag = 1'b1; // see RULE5
                if (q.phase == SSE_RX_DATA) begin
                  if (cfg_in.stretch_enable) begin
                    d.stat.clock_release_bit = 1'b0; // see RULE22
                  end
                end else if (cfg_in.ten_bit_mode && !q.low_stage && !q.rx_sr[0]) begin
                  d.stat.address_update_flag = 1'b1; // see RULE19
                  d.low_stage = 1'b1;
                  d.prior_match = 1'b0;
                end else if (ten_low) begin
                  d.stat.address_update_flag = 1'b1; // see RULE20
                  d.prior_match = low_hit;
                  d.phase = low_hit ? SSE_RX_DATA : SSE_IDLE;
                end else if (q.stat.read_status) begin
                  d.phase = SSE_TX_DATA;
                  d.stat.clock_release_bit = 1'b0; // see RULE9
                end else begin
                  d.phase = SSE_RX_DATA;
                  if (cfg_in.stretch_enable) begin
                    d.stat.clock_release_bit = 1'b0; // see RULE6
                  end
                end
              end
            end
            SSE_IDLE: begin
            end
          endcase
        end else if (q.phase == SSE_TX_DATA) begin
          d.shift_register = {q.shift_register[6:0], 1'b0}; // see RULE10
        end
      end
    end

    // Pin drive from the next state
    unique case (d.phase)
      SSE_TX_DATA: begin
        d.sda_oe = (d.bitcnt <= `SSE_LAST_DATA_BIT) & ~d.shift_register[7];
      end
      SSE_RX_ADDR, SSE_RX_DATA: begin
        // Next-state hold and refusal: the first ack cycle already carries
        // the level software chose, with no one-cycle pull on a chosen NACK
        d.sda_oe = (d.bitcnt == `SSE_ACK_SLOT) &
                   ~(d.nack_force | (d.ack_hold & cfg_in.ack_value_select)); // see RULE4
      end
      SSE_IDLE: begin
        d.sda_oe = 1'b0;
      end
    endcase
    // Pull SCL only once it is already low, so no high time is cut short
    hold_req = (~d.stat.clock_release_bit & (d.phase != SSE_IDLE)) |
               d.stat.address_update_flag; // see RULE19
    d.scl_oe = hold_req & (q.scl_oe | ~q.scl_s2);
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
      q.phase <= SSE_IDLE;
      q.own_address <= `SSE_OWN_ADDR_RST;
      q.shift_buffer <= `SSE_BYTE_RST;
      q.stat.clock_release_bit <= `SSE_CKP_RST;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain: the driven level is always low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = q.scl_oe;
  assign sda_oe_out = q.sda_oe;
  assign stat_out = q.stat;
  assign shift_buffer_out = q.shift_buffer;
  assign own_address_out = q.own_address;
endmodule
`default_nettype wire

// ==== sse_testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sse_pkg::*;
  // ----------------------------------------
  // Clocks, wires and design
  // ----------------------------------------
  localparam logic [6:0] rel = 7'h40, rd = 7'h20, wr = 7'h10, adr = 7'h08, evc = 7'h04;
  logic clk_sys_in = 1'b0;
  logic clk_link = 1'b0;
  logic reset_n_in = 1'b0;
  logic jam = 1'b0;
  logic clk_en = 1'b1;
  logic d_scl_oe, d_sda_oe, m_scl_oe, m_sda_oe, a;
  logic [7:0] d, sbuf, oaddr;
  sse_cfg_s cfg = '0;
  sse_sw_s sw = '0;
  sse_stat_s st;
  wire logic scl_w;
  wire logic sda_w;
  int miscompares = 0;
  int checked = 0;
  assign scl_w = !(d_scl_oe || m_scl_oe);
  assign sda_w = !(d_sda_oe || m_sda_oe);
  always #20 clk_sys_in = !clk_sys_in;
  initial begin
    #3;
    forever #6 clk_link = !clk_link;
  end
  sse_slave_engine uut (
    .clk_sys_in(clk_sys_in), .clk_en_in(clk_en), .reset_n_in(reset_n_in),
    .scl_link_in(scl_w), .scl_in(scl_w), .scl_out(), .scl_oe_out(d_scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe_out(d_sda_oe), .cfg_in(cfg), .sw_in(sw),
    .stat_out(st), .shift_buffer_out(sbuf), .own_address_out(oaddr)
  );
  sse_master m (
    .clk_link_in(clk_link), .scl_in(scl_w), .sda_in(sda_w), .jam_in(jam),
    .scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe)
  );
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task pulse(input logic [6:0] f, input logic [7:0] v);
    @(negedge clk_sys_in);
    sw = {f, v};
    @(negedge clk_sys_in);
    sw = '0;
  endtask
  task wait_ev();
    for (int n = 0; n < 5000 && st.port_event_flag !== 1'b1; n++) begin
      @(negedge clk_sys_in);
    end
    chk("event", 8'h01, st.port_event_flag);
  endtask
  task begin_test(input logic [5:0] c);
    @(negedge clk_sys_in);
    cfg = c;
    m.start();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_hold_write();
    pulse(adr, 8'ha4);
    begin_test(6'h30);
    fork
      m.xfer(8'ha4, 1'b1, d, a);
      begin
        wait_ev();
        chk("ckp", 8'h00, st.clock_release_bit);
        chk("ack_window_flag", 8'h01, st.ack_window_flag);
        pulse(rd | evc, 8'h00);
        chk("bf", 8'h00, st.buffer_full_flag);
        pulse(rel, 8'h00);
        wait_ev();
        chk("ack_window_flag", 8'h00, st.ack_window_flag);
        pulse(evc, 8'h00);
      end
    join
    chk("addr ack", 8'h01, a);
    fork
      m.xfer(8'h5b, 1'b1, d, a);
      begin
        wait_ev();
        chk("data ckp", 8'h00, st.clock_release_bit);
        chk("data", 8'h5b, sbuf);
        cfg.ack_value_select = 1'b1;
        pulse(rel | rd | evc, 8'h00);
      end
    join
    chk("data ack", 8'h00, a);
    repeat (20) @(negedge clk_sys_in);
    chk("nack event", 8'h00, st.port_event_flag);
    m.stop();
    chk("stop", 8'h01, st.stop_seen);
    $display("test hold_write done");
  endtask
  task t_read();
    begin_test(6'h20);
    fork
      m.xfer(8'ha5, 1'b1, d, a);
      begin
        wait_ev();
        chk("rd ckp", 8'h00, st.clock_release_bit);
        pulse(rd | evc | rel, 8'h00);
        wait_ev();
        chk("rw", 8'h01, st.read_status);
        chk("ack ckp", 8'h00, st.clock_release_bit);
        pulse(evc, 8'h00);
        pulse(wr, 8'h3c);
        chk("bf", 8'h01, st.buffer_full_flag);
        pulse(rel, 8'h00);
      end
    join
    chk("rd ack", 8'h01, a);
    m.xfer(8'hff, 1'b1, d, a);
    chk("tx data", 8'h3c, d);
    repeat (20) @(negedge clk_sys_in);
    chk("received_ack_flag", 8'h01, st.received_ack_flag);
    chk("tx event", 8'h01, st.port_event_flag);
    chk("no hold", 8'h00, d_scl_oe);
    m.stop();
    pulse(rd | evc, 8'h00);
    $display("test read done");
  endtask
  task t_collision();
    begin_test(6'h01);
    fork
      m.xfer(8'ha5, 1'b1, d, a);
      begin
        wait_ev();
        pulse(rd | evc, 8'h00);
        pulse(wr, 8'hff);
        pulse(rel, 8'h00);
      end
    join
    jam = 1'b1;
    m.xfer(8'hff, 1'b1, d, a);
    jam = 1'b0;
    chk("bcol", 8'h01, st.collision_event_flag);
    chk("sda idle", 8'h00, d_sda_oe);
    m.stop();
    pulse(rd | evc, 8'h00);
    $display("test collision done");
  endtask
  task t_ten_bit();
    pulse(adr, 8'h06);
    begin_test(6'h02);
    fork
      m.xfer(8'hf6, 1'b1, d, a);
      begin
        wait_ev();
        chk("ua", 8'h01, st.address_update_flag);
        pulse(rd | evc, 8'h00);
        repeat (30) @(negedge clk_sys_in);
        chk("ua hold", 8'h01, d_scl_oe);
        pulse(adr, 8'h5a);
        chk("ua clear", 8'h00, st.address_update_flag);
        chk("own addr", 8'h5a, oaddr);
      end
    join
    chk("hi ack", 8'h01, a);
    fork
      m.xfer(8'h33, 1'b1, d, a);
      begin
        wait_ev();
        chk("ua miss", 8'h01, st.address_update_flag);
        chk("bf miss", 8'h00, st.buffer_full_flag);
        chk("ckp miss", 8'h01, st.clock_release_bit);
        pulse(adr | evc, 8'h06);
      end
    join
    m.stop();
    $display("test ten_bit done");
  endtask
  task t_stretch();
    pulse(adr, 8'ha4);
    begin_test(6'h08);
    fork
      m.xfer(8'ha4, 1'b1, d, a);
      begin
        wait_ev();
        repeat (30) @(negedge clk_sys_in);
        chk("sen ckp", 8'h00, st.clock_release_bit);
        chk("sen hold", 8'h01, d_scl_oe);
        pulse(rel | evc, 8'h00);
      end
    join
    chk("sen addr ack", 8'h01, a);
    m.xfer(8'hc3, 1'b1, d, a);
    repeat (20) @(negedge clk_sys_in);
    chk("ovf nack", 8'h00, a);
    chk("ovf flag", 8'h01, st.receive_overflow_flag);
    chk("ovf buf", 8'ha4, sbuf);
    chk("ovf event", 8'h00, st.port_event_flag);
    m.stop();
    pulse(rd | evc | 7'h01, 8'h00);
    $display("test stretch done");
  endtask
  task report_and_stop();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    chk("ckp reset", 8'h01, st.clock_release_bit);
    clk_en = 1'b0;
    pulse(adr, 8'h77);
    clk_en = 1'b1;
    chk("frozen own addr", 8'h00, oaddr);
    $display("test freeze done");
    t_hold_write();
    t_read();
    t_collision();
    t_ten_bit();
    t_stretch();
    report_and_stop();
  end
endmodule
`default_nettype wire
